// ===== hdl/sahc_regs.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the serial storage host front end; included by the package.
 */
`ifndef SAHC_REGS_SVH
`define SAHC_REGS_SVH
`define SAHC_OFF_CAP 8'h00
`define SAHC_OFF_CTRL 8'h04
`define SAHC_OFF_LINK 8'h08
`define SAHC_OFF_STAT 8'h0C
`define SAHC_OFF_MASK 8'h10
`define SAHC_OFF_LOOP 8'h14
`define SAHC_OFF_ISSUE 8'h18
`define SAHC_OFF_HDR 8'h1C
`define SAHC_OFF_DESC 8'h20
`define SAHC_OFF_VER 8'h24
`define SAHC_CAP_PMULT 0
`define SAHC_CAP_FBS 1
`define SAHC_CAP_CPD 2
`define SAHC_CAP_RATE_LSB 4
`define SAHC_CAP_MPS 8
`define SAHC_CAP_LEGACY 9
`define SAHC_CTRL_RAID 0
`define SAHC_CTRL_START 1
`define SAHC_CTRL_CLO 2
`define SAHC_CTRL_LOOP 3
`define SAHC_CTRL_HP_EN 4
`define SAHC_CTRL_PMULT_EN 5
`define SAHC_CTRL_RATE_LSB 8
`define SAHC_LINK_BUSY 0
`define SAHC_LINK_PRES 1
`define SAHC_LINK_PM_LSB 2
`define SAHC_LINK_RATE_LSB 4
`define SAHC_LINK_WAKE 6
`define SAHC_EV_REMOVE 0
`define SAHC_EV_INSERT 1
`define SAHC_EV_PMREQ 2
`define SAHC_EV_LOOP_DONE 3
`define SAHC_EV_LOOP_ERR 4
`define SAHC_EV_WIDTH 5
`define SAHC_HDR_CFL_LSB 0
`define SAHC_HDR_PREF 7
`define SAHC_HDR_PRDTL_LSB 16
`define SAHC_LOOP_BYTES 16'h0100
`define SAHC_CAP_RATES 2'h3
`define SAHC_RATE_RST 2'h3
`define SAHC_VER_VALUE 32'h0001_0301
`define SAHC_WAKE_NS 106
`define SAHC_LOOP_WORDS 64
`define SAHC_DEBOUNCE 4
`endif

// ===== hdl/sahc_pkg.sv
/*
 * types shared by the host front end.
 * assumes sahc_regs.svh is on the include path.
 */
`default_nettype none
package sahc_pkg;
`include "sahc_regs.svh"
  typedef enum logic [1:0] {sahc_pm_active, sahc_pm_partial, sahc_pm_slumber} sahc_pm_t;
  typedef enum logic [1:0] {sahc_lp_idle, sahc_lp_fetch, sahc_lp_move, sahc_lp_end} sahc_lp_t;
  localparam int SAHC_CLK_MHZ = 250;
  localparam int SAHC_WAKE_CYC = (`SAHC_WAKE_NS * SAHC_CLK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

// ===== hdl/sahc_core.sv
/*
 * serial storage host front end: register file on avalon-mm,
 * hot-plug events, link power handling, loopback session engine.
 * assumes a phy outside that signals presence, power requests and wake.
 */
// Implementation choices: the register offsets and the Avalon-MM register port.
`default_nettype none
`include "sahc_regs.svh"
// Contract
// R1: runs in ahci or raid mode only
// R2: no legacy ide or combined mode
// R3: link behaviour per serial ata 3.2
// R4: full ahci 1.3 and 1.3.1 behaviour
// R5: optional command-based port multiplier capability
// R6: firmware clears multiplier capability if unsupported
// R7: loopback needs busy cleared by override first
// R8: loopback session issues one slot only
// R9: loopback slot uses one region descriptor
// R10: loopback descriptor exactly 256 bytes
// R11: frame length programmed zero, hardware ignores it
// R12: prefetchable flag set, no drive frame awaited
// R13: start cleared and reset between sessions
// R14: rates 6, 3 and 1.5 gb/s
// R15: hot-plug removal and insertion reported
// R16: switch ports allow partial, slumber with hot-plug
// R17: no fis switching, no cold presence detect
// R18: acknowledge drive power requests, never initiate
// R19: send wake before using low-power link
module sahc_core
  import sahc_pkg::*;
#(
  parameter bit PMULT_SUPPORTED = 1'b1,
  parameter bit HAS_MPS = 1'b1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  output logic irq,
  input wire logic phy_present,
  input wire logic phy_pm_partial_req,
  input wire logic phy_pm_slumber_req,
  input wire logic phy_wake_in,
  input wire logic phy_d2h_reg_fis,
  output logic phy_pm_ack,
  output logic phy_wake_out,
  output logic [1:0] phy_rate_sel,
  output logic dma_req,
  output logic loop_active
);
  typedef struct packed {
    logic [2:0] pres_s;
    logic [2:0] part_s;
    logic [2:0] slum_s;
    logic [2:0] wake_s;
    logic [2:0] fis_s;
    logic [31:0] rdata;
    logic wait_n;
    logic [1:0] resp;
    logic raid;
    logic start;
    logic loop_en;
    logic hp_en;
    logic pmult_en;
    logic [1:0] rate;
    logic busy;
    logic present;
    sahc_pm_t pm;
    logic [`SAHC_EV_WIDTH-1:0] stat;
    logic [`SAHC_EV_WIDTH-1:0] mask;
    logic [31:0] issue;
    logic [31:0] hdr;
    logic [15:0] desc_bytes;
    logic used;
    sahc_lp_t lp;
    logic [7:0] cnt;
    logic [7:0] wake_cnt;
    logic pm_ack;
    logic wake_out;
    logic irq;
    logic dma;
    logic loop_on;
    logic wreq;
  } sahc_state_t;

  sahc_state_t r;
  sahc_state_t next_r;
  logic acc;
  logic wr_ok;
  logic [`SAHC_EV_WIDTH-1:0] ev;
  logic [31:0] cap;
  logic [31:0] ctrl_rd;
  logic [31:0] link_rd;
  logic [31:0] wmask;

  for (genvar b = 0; b < 4; b++) begin : g_be
    assign wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
  end

  always_comb begin
    cap = 32'h0;
    // R5: multiplier capability, firmware may drop it
    // R6: strap cleared when unsupported
    cap[`SAHC_CAP_PMULT] = PMULT_SUPPORTED;
    // R17: unsupported features report zero
    cap[`SAHC_CAP_FBS] = 1'b0;
    cap[`SAHC_CAP_CPD] = 1'b0;
    // R14: all three rates
    cap[`SAHC_CAP_RATE_LSB +: 2] = `SAHC_CAP_RATES;
    cap[`SAHC_CAP_MPS] = HAS_MPS;
    // R2: no legacy mode advertised
    cap[`SAHC_CAP_LEGACY] = 1'b0;
    ctrl_rd = 32'h0;
    ctrl_rd[`SAHC_CTRL_RAID] = r.raid;
    ctrl_rd[`SAHC_CTRL_START] = r.start;
    ctrl_rd[`SAHC_CTRL_LOOP] = r.loop_en;
    ctrl_rd[`SAHC_CTRL_HP_EN] = r.hp_en;
    ctrl_rd[`SAHC_CTRL_PMULT_EN] = r.pmult_en;
    ctrl_rd[`SAHC_CTRL_RATE_LSB +: 2] = r.rate;
    link_rd = 32'h0;
    link_rd[`SAHC_LINK_BUSY] = r.busy;
    link_rd[`SAHC_LINK_PRES] = r.present;
    link_rd[`SAHC_LINK_PM_LSB +: 2] = r.pm;
    link_rd[`SAHC_LINK_RATE_LSB +: 2] = r.rate;
    link_rd[`SAHC_LINK_WAKE] = r.wake_out;
  end

  always_comb begin
    next_r = r;
    ev = '0;
    acc = (avs_read | avs_write) & ~r.wait_n;
    wr_ok = acc & avs_write;
    next_r.pres_s = {r.pres_s[1:0], phy_present};
    next_r.part_s = {r.part_s[1:0], phy_pm_partial_req};
    next_r.slum_s = {r.slum_s[1:0], phy_pm_slumber_req};
    next_r.wake_s = {r.wake_s[1:0], phy_wake_in};
    next_r.fis_s = {r.fis_s[1:0], phy_d2h_reg_fis};
    next_r.wait_n = acc;
    next_r.wreq = ~acc;
    next_r.resp = 2'h0;
    next_r.pm_ack = 1'b0;
    next_r.dma = 1'b0;
    // R15: presence edges raise events
    if (r.pres_s[1] != r.pres_s[2]) begin
      next_r.present = r.pres_s[1];
      // events only while hot-plug is enabled
      if (r.hp_en) begin
        ev[r.pres_s[1] ? `SAHC_EV_INSERT : `SAHC_EV_REMOVE] = 1'b1;
      end
    end
    // R3: drive register frame clears busy
    if (r.fis_s[1] && !r.fis_s[2]) begin
      next_r.busy = 1'b0;
    end
    // R18: ack drive power requests only
    // R16: allowed alongside hot-plug on switch ports
    if (r.pm == sahc_pm_active && r.lp == sahc_lp_idle &&
        (r.part_s[1] || r.slum_s[1]) && (HAS_MPS || !r.hp_en)) begin
      next_r.pm = r.slum_s[1] ? sahc_pm_slumber : sahc_pm_partial;
      next_r.pm_ack = 1'b1;
      ev[`SAHC_EV_PMREQ] = 1'b1;
    end
    if (r.pm != sahc_pm_active && r.wake_s[1]) begin
      next_r.pm = sahc_pm_active;
    end
    if (r.wake_cnt != 8'h00) begin
      next_r.wake_cnt = r.wake_cnt - 8'h01;
      if (r.wake_cnt == 8'h01) begin
        next_r.wake_out = 1'b0;
        next_r.pm = sahc_pm_active;
      end
    end
    // R7: loopback engine, busy must be overridden first
    case (r.lp)
      sahc_lp_idle: begin
        if (r.start && r.loop_en && !r.used && !r.busy && r.issue != 32'h0) begin
          // R19: wake the link before use
          if (r.pm != sahc_pm_active) begin
            if (r.wake_cnt == 8'h00 && !r.wake_out) begin
              next_r.wake_out = 1'b1;
              next_r.wake_cnt = 8'(SAHC_WAKE_CYC);
            end
          end else begin
            next_r.lp = sahc_lp_fetch;
            next_r.used = 1'b1;
          end
        end
      end
      sahc_lp_fetch: begin
        // R8: single slot bit
        // R9: one descriptor entry
        // R10: 256-byte descriptor
        // R12: prefetch flag, no frame wait
        // R11: frame length ignored
        if (($countones(r.issue) != 1) ||
            (r.hdr[`SAHC_HDR_PRDTL_LSB +: 16] != 16'h0001) ||
            (r.desc_bytes != `SAHC_LOOP_BYTES) || !r.hdr[`SAHC_HDR_PREF]) begin
          ev[`SAHC_EV_LOOP_ERR] = 1'b1;
          next_r.lp = sahc_lp_end;
        end else begin
          next_r.cnt = 8'h00;
          next_r.lp = sahc_lp_move;
        end
      end
      sahc_lp_move: begin
        next_r.dma = 1'b1;
        next_r.cnt = r.cnt + 8'h01;
        if (r.cnt == 8'(`SAHC_LOOP_WORDS - 1)) begin
          ev[`SAHC_EV_LOOP_DONE] = 1'b1;
          next_r.lp = sahc_lp_end;
        end
      end
      sahc_lp_end: begin
        next_r.issue = 32'h0;
        next_r.lp = sahc_lp_idle;
      end
      default: next_r.lp = sahc_lp_idle;
    endcase
    if (acc && avs_read) begin
      case (avs_address)
        `SAHC_OFF_CAP: next_r.rdata = cap;
        `SAHC_OFF_CTRL: next_r.rdata = ctrl_rd;
        `SAHC_OFF_LINK: next_r.rdata = link_rd;
        `SAHC_OFF_STAT: next_r.rdata = 32'(r.stat);
        `SAHC_OFF_MASK: next_r.rdata = 32'(r.mask);
        `SAHC_OFF_LOOP: next_r.rdata = {30'h0, r.lp};
        `SAHC_OFF_ISSUE: next_r.rdata = r.issue;
        `SAHC_OFF_HDR: next_r.rdata = r.hdr;
        `SAHC_OFF_DESC: next_r.rdata = {16'h0, r.desc_bytes};
        // R4: interface version
        `SAHC_OFF_VER: next_r.rdata = `SAHC_VER_VALUE;
        default: begin
          next_r.rdata = 32'h0;
          next_r.resp = 2'h2;
        end
      endcase
    end
    if (wr_ok) begin
      case (avs_address)
        `SAHC_OFF_CTRL: begin
          if (avs_byteenable[0]) begin
            // R1: raid or ahci select
            next_r.raid = avs_writedata[`SAHC_CTRL_RAID];
            // R13: clearing start rearms the session
            if (!avs_writedata[`SAHC_CTRL_START]) begin
              next_r.used = 1'b0;
            end
            next_r.start = avs_writedata[`SAHC_CTRL_START];
            // R7: override clears busy
            if (avs_writedata[`SAHC_CTRL_CLO]) begin
              next_r.busy = 1'b0;
            end
            next_r.loop_en = avs_writedata[`SAHC_CTRL_LOOP];
            next_r.hp_en = avs_writedata[`SAHC_CTRL_HP_EN];
            next_r.pmult_en = avs_writedata[`SAHC_CTRL_PMULT_EN] & PMULT_SUPPORTED;
          end
          if (avs_byteenable[1]) begin
            next_r.rate = avs_writedata[`SAHC_CTRL_RATE_LSB +: 2];
          end
        end
        `SAHC_OFF_STAT: next_r.stat = r.stat & ~avs_writedata[`SAHC_EV_WIDTH-1:0];
        `SAHC_OFF_MASK: next_r.mask = avs_writedata[`SAHC_EV_WIDTH-1:0];
        `SAHC_OFF_ISSUE: next_r.issue = (r.issue & ~wmask) | (avs_writedata & wmask);
        `SAHC_OFF_HDR: next_r.hdr = (r.hdr & ~wmask) | (avs_writedata & wmask);
        `SAHC_OFF_DESC: next_r.desc_bytes = avs_writedata[15:0];
        `SAHC_OFF_CAP, `SAHC_OFF_LINK, `SAHC_OFF_LOOP, `SAHC_OFF_VER: ;
        default: next_r.resp = 2'h2;
      endcase
    end
    // set wins over write-one clear
    next_r.stat = next_r.stat | ev;
    next_r.irq = |(next_r.stat & next_r.mask);
    // flop copy so the session flag leaves a register
    next_r.loop_on = (next_r.lp != sahc_lp_idle);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.busy <= 1'b1;
      r.wreq <= 1'b1;
      r.rate <= `SAHC_RATE_RST;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.wreq;
  assign avs_response = r.resp;
  assign irq = r.irq;
  assign phy_pm_ack = r.pm_ack;
  assign phy_wake_out = r.wake_out;
  assign phy_rate_sel = r.rate;
  assign dma_req = r.dma;
  assign loop_active = r.loop_on;
endmodule // sahc_core
`default_nettype wire

// ===== test/sahc_core_props.sv
/* checker for the sahc_core ports.
   bound to every sahc_core instance at the foot of this file. */
`default_nettype none
module sahc_core_props
  import sahc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic irq,
  input wire logic phy_pm_ack,
  input wire logic phy_wake_out,
  input wire logic dma_req,
  input wire logic loop_active
);
  int wcnt;
  int dcnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // length of the current wake and transfer bursts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wcnt <= 0;
      dcnt <= 0;
    end else begin
      wcnt <= phy_wake_out ? wcnt + 1 : 0;
      dcnt <= dma_req ? dcnt + 1 : 0;
    end
  end
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("answer late");
  a_bus_single: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
  a_unmapped_err: assert property (
    !avs_waitrequest && avs_read && avs_address > 8'h24 |-> avs_response == 2'h2
    && avs_readdata == 32'h0) else $error("unmapped read not refused");
  a_ack_pulse: assert property (
    phy_pm_ack |=> !phy_pm_ack) else $error("ack not a pulse");
  a_wake_length: assert property (
    $fell(phy_wake_out) |-> wcnt == SAHC_WAKE_CYC) else $error("wake length wrong");
  a_dma_length: assert property (
    $fell(dma_req) |-> dcnt == 32'h40) else $error("transfer length wrong");
  a_dma_in_loop: assert property (
    dma_req |-> loop_active) else $error("transfer outside session");
  a_wake_before_dma: assert property (
    $rose(dma_req) |-> !phy_wake_out) else $error("transfer during wake");
  c_loop: cover property ($fell(dma_req));
  c_irq: cover property ($rose(irq));
  c_ack: cover property (phy_pm_ack);
endmodule // sahc_core_props
bind sahc_core sahc_core_props chk_u (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .irq(irq),
  .phy_pm_ack(phy_pm_ack), .phy_wake_out(phy_wake_out), .dma_req(dma_req),
  .loop_active(loop_active));
`default_nettype wire

// ===== test/sahc_drive_model.sv
/* drive-side stand-in for the phy lines of sahc_core.
   the bench steers presence and power requests. */
`default_nettype none
module sahc_drive_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic plug,
  input wire logic [1:0] pm_want,
  input wire logic phy_pm_ack,
  input wire logic phy_wake_out,
  output logic phy_present,
  output logic phy_pm_partial_req,
  output logic phy_pm_slumber_req,
  output logic phy_wake_in,
  output logic phy_d2h_reg_fis
);
  logic got;
  assign phy_d2h_reg_fis = 1'b0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_present <= 1'b0;
      got <= 1'b0;
      phy_pm_partial_req <= 1'b0;
      phy_pm_slumber_req <= 1'b0;
      phy_wake_in <= 1'b0;
    end else begin
      phy_present <= plug;
      got <= (got || phy_pm_ack) && pm_want != 2'h0;
      phy_pm_partial_req <= pm_want == 2'h1 && !got && !phy_pm_ack;
      phy_pm_slumber_req <= pm_want == 2'h2 && !got && !phy_pm_ack;
      phy_wake_in <= $fell(phy_wake_out);
    end
  end
endmodule // sahc_drive_model
`default_nettype wire

// ===== test/sahc_core_tb.sv
/* self-checking bench for sahc_core.
   assumes the checker is bound and the drive model plays the far side. */
`default_nettype none
module sahc_core_tb import sahc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0, plug = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
  logic [1:0] pm_want = 2'h0, avs_response, rresp, phy_rate_sel;
  logic avs_waitrequest, irq, phy_pm_ack, phy_wake_out, dma_req, loop_active;
  logic phy_present, phy_pm_partial_req, phy_pm_slumber_req, phy_wake_in, phy_d2h_reg_fis;
  int err_count = 0, n_tests = 0, wc = 0, dc = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    wc += (phy_wake_out === 1'b1);
    dc += (dma_req === 1'b1);
  end
  // firmware strap kept: multipliers supported on this board
  sahc_core #(.PMULT_SUPPORTED(1'b1), .HAS_MPS(1'b1)) dut_u (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .irq(irq), .phy_present(phy_present),
    .phy_pm_partial_req(phy_pm_partial_req), .phy_pm_slumber_req(phy_pm_slumber_req),
    .phy_wake_in(phy_wake_in), .phy_d2h_reg_fis(phy_d2h_reg_fis), .phy_pm_ack(phy_pm_ack),
    .phy_wake_out(phy_wake_out), .phy_rate_sel(phy_rate_sel), .dma_req(dma_req),
    .loop_active(loop_active));
  sahc_drive_model drv_u (.clk(clk), .rst_b(rst_b), .plug(plug), .pm_want(pm_want),
    .phy_pm_ack(phy_pm_ack), .phy_wake_out(phy_wake_out), .phy_present(phy_present),
    .phy_pm_partial_req(phy_pm_partial_req), .phy_pm_slumber_req(phy_pm_slumber_req),
    .phy_wake_in(phy_wake_in), .phy_d2h_reg_fis(phy_d2h_reg_fis));
  task summarize;
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n == 20) err_count++;
    rdata = avs_readdata;
    rresp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task t_caps;
    bus(0, 8'h00, 0);
    chk("cap", rdata & 32'h337, 32'h131);
    bus(0, 8'h24, 0);
    chk("ver", rdata, 32'h0001_0301);
    bus(0, 8'h40, 0);
    chk("resp", rresp, 2'h2);
    for (int r = 1; r < 4; r++) begin
      bus(1, 8'h04, {22'h0, r[1:0], 8'h11});
      bus(0, 8'h04, 0);
      chk("ctrl", rdata & 32'h33B, {22'h0, r[1:0], 8'h11});
      chk("rate", phy_rate_sel, r[1:0]);
    end
    bus(1, 8'h04, 32'h310);
    bus(1, 8'h10, 32'h1F);
  endtask
  task t_hot;
    plug <= 1'b0;
    repeat (8) @(posedge clk);
    chk("irq", irq, 1);
    bus(0, 8'h0C, 0);
    chk("remove", rdata[1:0], 2'h1);
    bus(0, 8'h08, 0);
    chk("gone", rdata[1], 0);
    bus(1, 8'h0C, 32'h1);
    chk("irq_clr", irq, 0);
    bus(1, 8'h10, 32'h0);
    plug <= 1'b1;
    repeat (8) @(posedge clk);
    chk("irq_mask", irq, 0);
    bus(0, 8'h0C, 0);
    chk("insert", rdata[1:0], 2'h2);
    bus(0, 8'h08, 0);
    chk("present", rdata[1], 1);
    bus(1, 8'h0C, 32'h2);
    bus(1, 8'h10, 32'h1F);
  endtask
  task t_pm(input logic [1:0] m);
    int n;
    n = 0;
    pm_want <= m;
    do begin
      @(posedge clk);
      n++;
    end while (phy_pm_ack !== 1'b1 && n < 20);
    pm_want <= 2'h0;
    chk("ack", n < 20, 1);
    bus(0, 8'h08, 0);
    chk("pm", rdata[3:2], m);
    bus(1, 8'h0C, 32'h4);
  endtask
  task t_loop(input logic [31:0] hdr, desc, slot, input logic ok, input int wake);
    int n;
    n = 0;
    wc = 0;
    dc = 0;
    bus(1, 8'h1C, hdr);
    bus(1, 8'h20, desc);
    bus(1, 8'h04, 32'h31C);
    bus(1, 8'h18, slot);
    bus(1, 8'h04, 32'h31A);
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1 && n < 300);
    chk("done", n < 300, 1);
    repeat (2) @(posedge clk);
    chk("wake", wc, wake);
    chk("dma", dc, ok ? 64 : 0);
    bus(0, 8'h0C, 0);
    chk("end", rdata[4:3], ok ? 2'h1 : 2'h2);
    bus(0, 8'h18, 0);
    if (ok) chk("slot", rdata, 0);
    bus(1, 8'h0C, 32'h18);
    bus(1, 8'h04, 32'h318);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    chk("wreq", avs_waitrequest, 1);
    chk("rate0", phy_rate_sel, 2'h3);
    rst_b <= 1'b1;
    t_caps;
    t_hot;
    t_pm(2'h1);
    t_loop(32'h0001_0085, 32'h100, 32'h1, 1'b1, SAHC_WAKE_CYC);
    t_loop(32'h0001_0085, 32'h80, 32'h1, 1'b0, 0);
    t_loop(32'h0001_0085, 32'h100, 32'h3, 1'b0, 0);
    t_loop(32'h0002_0085, 32'h100, 32'h1, 1'b0, 0);
    t_pm(2'h2);
    t_loop(32'h0001_0085, 32'h100, 32'h4, 1'b1, SAHC_WAKE_CYC);
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize;
  end
endmodule // sahc_core_tb
`default_nettype wire
